// ### hw/ued_engine.sv
// Device-side endpoint engine and its transmit FIFO.
// Assumes a synchronous packet RAM port with one cycle read latency
// and a serial engine that delivers tokens and bytes on CLK_IN.
// Notes on behaviour
// - Endpoint zero uses fixed base and control enables.
// - Config bits select buffering and buffer interrupts.
// - Config encodes endpoint type, stall/NAK interrupt enables.
// - Config gives 64-byte aligned buffer base.
// - Single buffering uses only the lower half.
// - Double buffering alternates selector from buffer zero, except isochronous IN.
// - Upper half holds buffer one fields.
// - Isochronous second buffer offset 128 to 1024.
// - Available bit hands each half to controller.
// - Lower half holds buffer zero fields.
// - Select-reset bit forces buffer zero, then clears.
// - Stall bit requests STALL handshake.
// - SETUP always stored at zero; ACKed, flagged only if error-free with eight or more bytes.
// - Endpoint zero stall needs arm bit too.
// - IN answers STALL, data, NAK or silence.
// - IN data then await ACK or timeout, except isochronous.
// - Status phase writes back half and flags.
// - Non-isochronous OUT data PID mismatch raises sequence error.
// - OUT accepted when available and not full.
// - OUT stored, ACKed unless isochronous, full set.
// - Missing frames suspend; remote resume on request.
// - Packet RAM holds words low, buffers above.
`timescale 1ns/100ps
`include "ued_defines.svh"

module ued_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic in_valid_in, // Write request.
  output logic in_ready_out, // Space available.
  input wire logic [WIDTH-1:0] in_data_in, // Write word.
  output logic out_valid_out, // Word available.
  input wire logic out_ready_in, // Consumer takes word.
  output logic [WIDTH-1:0] out_data_out // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;
  // Handshakes are combinational; storage is flip-flops.
  assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem_reg[rp_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data_in;
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  fifo_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_reg <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

module ued_engine #(
  parameter int SUSP_CYCLES = `UED_SUSP_US * `UED_CLK_MHZ,
  parameter int RSM_CYCLES = `UED_RSM_US * `UED_CLK_MHZ
) (
  input wire logic CLK_IN, // 50 MHz system clock.
  input wire logic SYS_RST_IN, // Synchronous reset, active high.
  input wire logic TOKEN_VALID_IN, // Token received, pulse.
  input wire ued_pkg::ued_token_type TOKEN_PID_IN, // Token kind.
  input wire logic [3:0] TOKEN_EP_IN, // Token endpoint number.
  input wire logic RX_VALID_IN, // Received data byte, pulse.
  input wire logic [7:0] RX_BYTE_IN, // Received byte.
  input wire logic RX_END_IN, // Data packet ended, pulse.
  input wire logic RX_PID_IN, // Data PID of packet, DATA1 high.
  input wire logic RX_ERR_IN, // Packet had CRC or bit errors.
  input wire logic ACK_IN, // Host ACK received, pulse.
  input wire logic TIMEOUT_IN, // No host reply, pulse.
  input wire logic SOF_IN, // Start of frame seen, pulse.
  input wire logic EP0_IRQ_BUF_IN, // Ep0 per-buffer enable.
  input wire logic EP0_IRQ_STALL_IN, // Ep0 stall event enable.
  input wire logic EP0_IRQ_NAK_IN, // Ep0 NAK event enable.
  input wire logic REMOTE_RESUME_IN, // Start remote resume.
  input wire logic [1:0] STALL_ARM_SET_IN, // Arm ep0 IN/OUT stall.
  output logic [1:0] STALL_ARM_OUT, // Ep0 stall gate bits.
  input wire logic [7:0] STATUS_CLR_IN, // Clear status flags.
  output logic [7:0] STATUS_OUT, // Sticky status flags.
  input wire logic [31:0] DONE_CLR_IN, // Clear buffer-done bits.
  output logic [31:0] DONE_OUT, // Buffer done per ep/dir.
  input wire logic [31:0] PEND_CLR_IN, // Clear pending bits.
  output logic [31:0] PEND0_OUT, // Buffer 0 half pending.
  output logic [31:0] PEND1_OUT, // Buffer 1 half pending.
  output logic SUSPENDED_OUT, // Device is suspended.
  output logic RESUME_DRIVE_OUT, // Drive resume signalling.
  output logic HS_VALID_OUT, // Send handshake, pulse.
  output ued_pkg::ued_hs_type HS_CODE_OUT, // Handshake kind.
  output logic TX_VALID_OUT, // Transmit byte available.
  input wire logic TX_READY_IN, // Serial engine takes byte.
  output logic [7:0] TX_BYTE_OUT, // Transmit byte.
  output logic TX_LAST_OUT, // Last byte of packet.
  output logic TX_ZLP_OUT, // Packet has no data.
  output logic TX_PID_OUT, // Data PID, DATA1 high.
  output logic RAM_RD_OUT, // Packet RAM read.
  output logic RAM_WR_OUT, // Packet RAM write.
  output logic [9:0] RAM_ADDR_OUT, // Packet RAM word index.
  output logic [3:0] RAM_BE_OUT, // Byte enables.
  output logic [31:0] RAM_WDATA_OUT, // Write data.
  input wire logic [31:0] RAM_RDATA_IN // Read data, next cycle.
);
  import ued_pkg::*;

  ued_regs_type r_reg, r_next;
  logic [31:0] cfg_eff;
  logic [15:0] h;
  logic [11:0] dbase;
  logic [4:0] idx;
  logic iso, dbl, stall_req, fifo_rdy, rx_good;
  logic [10:0] fifo_word;
  logic [7:0] fset;
  logic [15:0] newh;
  logic [31:0] dset, p0set, p1set;

  // Endpoint zero has no configuration word; build one from control
  // inputs so the rest of the engine sees one uniform layout.
  assign cfg_eff = (r_reg.ep == 4'h0) ?
    {2'b00, EP0_IRQ_BUF_IN, 1'b0, EP_CTRL, 8'h00, EP0_IRQ_STALL_IN,
     EP0_IRQ_NAK_IN, `UED_EP0_BASE, 6'h00} : r_reg.cfg;
  assign iso = (cfg_eff[`UED_CFG_TYPE] == EP_ISO);
  assign dbl = cfg_eff[`UED_CFG_DOUBLE];
  assign idx = {r_reg.ep, r_reg.dir};
  // Only the selected half is examined; upper half ignored if single.
  assign h = r_reg.half ? r_reg.buf_w[31:16] :
    r_reg.buf_w[15:0];
  // Low six address bits are forced to zero by construction.
  // The packet RAM spans 4096 bytes, so the sum is cut to twelve bits.
  assign dbase = 12'({cfg_eff[`UED_CFG_BASE], 6'h00} +
    (!r_reg.half ? 12'h000 :
     iso ? (`UED_ISO_OFS_MIN << r_reg.buf_w[`UED_B_ISO_OFS]) :
     `UED_BUF1_STEP));
  assign stall_req = r_reg.buf_w[`UED_B_STALL] &&
    (r_reg.ep != 4'h0 || r_reg.gate[r_reg.dir]);
  assign rx_good = !RX_ERR_IN;
  // Written-back half: other bits of that half go to zero. The OUT
  // length was already saved in buf_w, as the counter is reused.
  assign newh = {r_reg.dir, h[`UED_H_LAST], r_reg.pid,
    3'b000, h[`UED_H_LEN]};
  assign fifo_word = {h[`UED_H_PID], h[`UED_H_LEN] == 10'h000,
    h[`UED_H_LEN] == 10'h000 || r_reg.cnt == h[`UED_H_LEN] - 10'h001,
    RAM_RDATA_IN[{r_reg.lane, 3'b000} +: 8]};

  // Transmit FIFO sits between the packet RAM and the serial engine.
  ued_fifo #(.WIDTH(11), .DEPTH(4)) u_txf (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(r_reg.st == S_TXPUSH),
    .in_ready_out(fifo_rdy),
    .in_data_in(fifo_word),
    .out_valid_out(TX_VALID_OUT),
    .out_ready_in(TX_READY_IN),
    .out_data_out({TX_PID_OUT, TX_ZLP_OUT, TX_LAST_OUT, TX_BYTE_OUT})
  );

  // Next-state logic for the whole engine.
  always_comb begin
    r_next = r_reg;
    fset = 8'h00;
    dset = 32'h0;
    p0set = 32'h0;
    p1set = 32'h0;
    r_next.hs_v = 1'b0;
    r_next.ram_rd = 1'b0;
    r_next.ram_wr = 1'b0;
    r_next.gate = r_reg.gate | STALL_ARM_SET_IN;
    case (r_reg.st)
      S_IDLE: begin
        // Tokens arriving while busy are ignored.
        if (TOKEN_VALID_IN) begin
          r_next.ep = TOKEN_EP_IN;
          r_next.cnt = 10'h000;
          r_next.setup = (TOKEN_PID_IN == TK_SETUP);
          r_next.dir = (TOKEN_PID_IN != TK_IN);
          if (TOKEN_PID_IN == TK_SETUP) begin
            r_next.st = S_RXD;
          end else begin
            r_next.ram_rd = 1'b1;
            r_next.ram_addr = {5'h00, TOKEN_EP_IN, TOKEN_PID_IN == TK_OUT};
            r_next.st = S_CFG;
          end
        end
      end
      S_CFG: begin
        r_next.ram_rd = 1'b1;
        r_next.ram_addr = 10'(({6'h00, idx, 2'b00} +
          `UED_BUFW_BASE) >> 2);
        r_next.st = S_BUFR;
      end
      S_BUFR: begin
        r_next.cfg = RAM_RDATA_IN;
        r_next.st = S_DEC;
      end
      S_DEC: begin
        r_next.buf_w = RAM_RDATA_IN;
        // The select-reset bit overrides the stored selector.
        r_next.half = dbl && r_reg.sel[idx] &&
          !RAM_RDATA_IN[`UED_B_RSTSEL];
        r_next.st = S_STAT;
      end
      S_STAT: begin
        // Decision cycle: buffer word is now in buf_w.
        r_next.pid = h[`UED_H_PID];
        if (stall_req) begin
          r_next.hs_v = 1'b1;
          r_next.hs_code = HS_STALL;
          fset[`UED_F_STALL] = cfg_eff[`UED_CFG_IRQ_STALL];
          r_next.st = S_IDLE;
        end else if (!r_reg.dir && h[`UED_H_AVAIL] &&
                     h[`UED_H_FULL]) begin
          r_next.st = (h[`UED_H_LEN] == 10'h000) ? S_TXCAP : S_TXRD;
        end else if (r_reg.dir && h[`UED_H_AVAIL] &&
                     !h[`UED_H_FULL]) begin
          r_next.st = S_RXD;
        end else begin
          r_next.hs_v = !iso;
          r_next.hs_code = HS_NAK;
          fset[`UED_F_NAK] = !iso && cfg_eff[`UED_CFG_IRQ_NAK];
          r_next.st = S_IDLE;
        end
        if (r_reg.cnt == `UED_LEN_MAX) begin
          // Second pass through S_STAT is the status write phase.
          r_next.hs_v = 1'b0;
          fset = 8'h00;
          r_next.st = S_IDLE;
          r_next.ram_wr = 1'b1;
          r_next.ram_be = 4'hf;
          r_next.ram_addr = 10'(({6'h00, idx, 2'b00} +
            `UED_BUFW_BASE) >> 2);
          r_next.ram_wdata = r_reg.half ?
            {newh, r_reg.buf_w[15:0] & 16'hefff} :
            {r_reg.buf_w[31:16], newh};
          r_next.cnt = 10'h000;
          fset[`UED_F_DONE] = h[`UED_H_LAST];
          if (dbl) begin
            r_next.sel[idx] = !r_reg.half;
          end
          dset[idx] = cfg_eff[`UED_CFG_IRQ_BUF] ||
            (cfg_eff[`UED_CFG_IRQ_TWO] && dbl && r_reg.half);
          p0set[idx] = !r_reg.half;
          p1set[idx] = r_reg.half;
        end
      end
      S_TXRD: begin
        // Only one read is in flight, so space seen here stays free.
        if (fifo_rdy) begin
          r_next.ram_rd = 1'b1;
          r_next.ram_addr = 10'((dbase + {2'b00, r_reg.cnt}) >> 2);
          r_next.lane = 2'(dbase + {2'b00, r_reg.cnt});
          r_next.st = S_TXCAP;
        end
      end
      S_TXCAP: r_next.st = S_TXPUSH;
      S_TXPUSH: begin
        if (fifo_rdy) begin
          r_next.cnt = r_reg.cnt + 10'h001;
          if (fifo_word[8]) begin
            r_next.cnt = iso ? 10'h000 : `UED_LEN_MAX;
            r_next.st = iso ? S_IDLE : S_ACKW;
          end else begin
            r_next.st = S_TXRD;
          end
        end
      end
      S_ACKW: begin
        if (ACK_IN) begin
          r_next.st = S_STAT;
        end else if (TIMEOUT_IN) begin
          fset[`UED_F_TMO] = 1'b1;
          r_next.st = S_IDLE;
        end
      end
      S_RXD: begin
        if (RX_VALID_IN && (r_reg.setup ? r_reg.cnt < `UED_SETUP_LEN :
                            r_reg.cnt != `UED_LEN_MAX)) begin
          r_next.ram_wr = 1'b1;
          r_next.ram_addr = 10'((r_reg.setup ? `UED_SETUP_BASE + {2'b00,
            r_reg.cnt} : dbase + {2'b00, r_reg.cnt}) >> 2);
          r_next.ram_be = 4'h1 << (2'(r_reg.cnt) +
            (r_reg.setup ? 2'b00 : 2'(dbase)));
          r_next.ram_wdata = {4{RX_BYTE_IN}};
          r_next.cnt = r_reg.cnt + 10'h001;
        end
        if (RX_END_IN) begin
          r_next.st = S_IDLE;
          if (r_reg.setup) begin
            if (rx_good && r_reg.cnt == `UED_SETUP_LEN) begin
              r_next.hs_v = 1'b1;
              r_next.hs_code = HS_ACK;
              fset[`UED_F_SETUP] = 1'b1;
              r_next.gate = 2'b00;
            end
          end else if (rx_good) begin
            if (!iso && RX_PID_IN != r_reg.pid) begin
              fset[`UED_F_SEQ] = 1'b1;
            end else begin
              r_next.hs_v = !iso;
              r_next.hs_code = HS_ACK;
              r_next.pid = RX_PID_IN;
              r_next.buf_w[{r_reg.half, 4'h0} +: 10] = r_reg.cnt;
              r_next.st = S_STAT;
            end
          end
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    // OUT status pass reuses the counter; length was saved in buf_w.
    if (r_reg.st == S_RXD && r_next.st == S_STAT) begin
      r_next.cnt = `UED_LEN_MAX;
    end
    // Frame watchdog and remote resume share one timer.
    if (SOF_IN) begin
      r_next.tmr = 18'h00000;
      r_next.rsm_drv = 1'b0;
      r_next.susp = 1'b0;
      fset[`UED_F_RSM] = r_reg.susp;
    end else if (r_reg.rsm_drv) begin
      r_next.tmr = r_reg.tmr + 18'h00001;
      if (r_reg.tmr == 18'(RSM_CYCLES - 1)) begin
        r_next.rsm_drv = 1'b0;
        r_next.tmr = 18'h00000;
      end
    end else if (r_reg.susp) begin
      if (REMOTE_RESUME_IN) begin
        r_next.rsm_drv = 1'b1;
        r_next.tmr = 18'h00000;
      end
    end else if (r_reg.tmr == 18'(SUSP_CYCLES - 1)) begin
      r_next.susp = 1'b1;
      r_next.tmr = 18'h00000;
      fset[`UED_F_SUSP] = 1'b1;
    end else begin
      r_next.tmr = r_reg.tmr + 18'h00001;
    end
    // Hardware sets win over software clears in the same cycle.
    r_next.flags = (r_reg.flags & ~STATUS_CLR_IN) | fset;
    // A bit set again while software clears it stays set.
    r_next.done = (r_reg.done & ~DONE_CLR_IN) | dset;
    r_next.pend0 = (r_reg.pend0 & ~PEND_CLR_IN) | p0set;
    r_next.pend1 = (r_reg.pend1 & ~PEND_CLR_IN) | p1set;
  end

  // The single state register of the engine.
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.hs_code <= HS_ACK;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register.
  assign STALL_ARM_OUT = r_reg.gate;
  assign STATUS_OUT = r_reg.flags;
  assign DONE_OUT = r_reg.done;
  assign PEND0_OUT = r_reg.pend0;
  assign PEND1_OUT = r_reg.pend1;
  assign SUSPENDED_OUT = r_reg.susp;
  assign RESUME_DRIVE_OUT = r_reg.rsm_drv;
  assign HS_VALID_OUT = r_reg.hs_v;
  assign HS_CODE_OUT = r_reg.hs_code;
  assign RAM_RD_OUT = r_reg.ram_rd;
  assign RAM_WR_OUT = r_reg.ram_wr;
  assign RAM_ADDR_OUT = r_reg.ram_addr;
  assign RAM_BE_OUT = r_reg.ram_be;
  assign RAM_WDATA_OUT = r_reg.ram_wdata;

  // Checks on the engine, all in the system clock domain.
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic dec_c;
  assign dec_c = (r_reg.st == S_STAT) && (r_reg.cnt != `UED_LEN_MAX);

  setup_ack_a: assert property (
    r_reg.st == S_RXD && r_reg.setup && RX_END_IN && rx_good &&
    r_reg.cnt == `UED_SETUP_LEN |=> HS_VALID_OUT &&
    HS_CODE_OUT == HS_ACK && STATUS_OUT[`UED_F_SETUP] &&
    STALL_ARM_OUT == 2'b00 ##1 !HS_VALID_OUT)
    else $error("setup not acknowledged");
  stall_reply_a: assert property (
    dec_c && stall_req |=> HS_VALID_OUT && HS_CODE_OUT == HS_STALL &&
    r_reg.st == S_IDLE)
    else $error("stall not sent");
  ep0_unarmed_a: assert property (
    dec_c && r_reg.ep == 4'h0 && !r_reg.gate[r_reg.dir] |=>
    !(HS_VALID_OUT && HS_CODE_OUT == HS_STALL))
    else $error("unarmed ep0 stalled");
  iso_silent_a: assert property (
    dec_c && !stall_req && iso && !(h[`UED_H_AVAIL] &&
    (r_reg.dir ^ h[`UED_H_FULL])) |=> !HS_VALID_OUT)
    else $error("iso endpoint got handshake");
  ack_status_a: assert property (
    r_reg.st == S_ACKW && ACK_IN |=> r_reg.st == S_STAT ##1
    RAM_WR_OUT && r_reg.st == S_IDLE)
    else $error("no status after ack");
  timeout_a: assert property (
    r_reg.st == S_ACKW && !ACK_IN && TIMEOUT_IN |=>
    STATUS_OUT[`UED_F_TMO] && r_reg.st == S_IDLE)
    else $error("timeout not flagged");
  seq_err_a: assert property (
    r_reg.st == S_RXD && !r_reg.setup && RX_END_IN && rx_good &&
    !iso && RX_PID_IN != r_reg.pid |=> STATUS_OUT[`UED_F_SEQ] &&
    !HS_VALID_OUT)
    else $error("pid mismatch not flagged");
  full_wb_a: assert property (
    r_reg.st == S_STAT && r_reg.cnt == `UED_LEN_MAX |=> RAM_WR_OUT &&
    (RAM_WDATA_OUT[{$past(r_reg.half), 4'hf}] == $past(r_reg.dir)))
    else $error("full bit written back wrong");
  sel_flip_a: assert property (
    r_reg.st == S_STAT && r_reg.cnt == `UED_LEN_MAX && dbl |=>
    r_reg.sel[$past(idx)] == !$past(r_reg.half))
    else $error("selector did not flip");
  suspend_a: assert property (
    $rose(SUSPENDED_OUT) |-> STATUS_OUT[`UED_F_SUSP] &&
    !$past(SOF_IN))
    else $error("suspend without flag");
  in_cov_c: cover property (r_reg.st == S_ACKW ##1 r_reg.st == S_STAT);
  out_cov_c: cover property (r_reg.st == S_RXD && r_reg.dir &&
    RX_END_IN ##1 r_reg.st == S_STAT);
  setup_cov_c: cover property (r_reg.setup && HS_VALID_OUT);
  susp_cov_c: cover property (RESUME_DRIVE_OUT);
endmodule

// ### common/ued_defines.svh
// Constants for the endpoint engine: word layouts and timing.
// Assumes a 4096-byte shared packet RAM with 32-bit words.
`ifndef UED_DEFINES_SVH
`define UED_DEFINES_SVH
`define UED_CFG_DOUBLE 30
`define UED_CFG_IRQ_BUF 29
`define UED_CFG_IRQ_TWO 28
`define UED_CFG_TYPE 27:26
`define UED_CFG_IRQ_STALL 17
`define UED_CFG_IRQ_NAK 16
`define UED_CFG_BASE 15:6
`define UED_H_FULL 15
`define UED_H_LAST 14
`define UED_H_PID 13
`define UED_B_RSTSEL 12
`define UED_B_STALL 11
`define UED_H_AVAIL 10
`define UED_H_LEN 9:0
`define UED_B_ISO_OFS 28:27
`define UED_ISO_OFS_MIN 12'h080
`define UED_BUF1_STEP 12'h040
`define UED_EP0_BASE 10'h004
`define UED_SETUP_BASE 12'h000
`define UED_BUFW_BASE 12'h080
`define UED_SETUP_LEN 10'h008
`define UED_LEN_MAX 10'h3ff
`define UED_F_SETUP 0
`define UED_F_DONE 1
`define UED_F_SEQ 2
`define UED_F_TMO 3
`define UED_F_SUSP 4
`define UED_F_RSM 5
`define UED_F_STALL 6
`define UED_F_NAK 7
`define UED_CLK_MHZ 50
`define UED_SUSP_US 3000
`define UED_RSM_US 2000
`endif

// ### common/ued_pkg.sv
// Types shared by the endpoint engine and its users.
// Assumes ued_defines.svh for all numeric layouts.
package ued_pkg;
  typedef enum logic [1:0] {TK_SETUP = 2'h0, TK_IN = 2'h1,
                            TK_OUT = 2'h2} ued_token_type;
  typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1,
                            HS_STALL = 2'h2} ued_hs_type;
  typedef enum logic [1:0] {EP_CTRL = 2'h0, EP_ISO = 2'h1,
                            EP_BULK = 2'h2, EP_INT = 2'h3} ued_ep_type;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_CFG = 10'h002, S_BUFR = 10'h004,
    S_DEC = 10'h008, S_TXRD = 10'h010, S_TXCAP = 10'h020,
    S_TXPUSH = 10'h040, S_ACKW = 10'h080, S_RXD = 10'h100,
    S_STAT = 10'h200} ued_state_type;
  typedef struct packed {
    ued_state_type st;
    logic [3:0] ep;
    logic dir;
    logic setup;
    logic [31:0] cfg;
    logic [31:0] buf_w;
    logic half;
    logic pid;
    logic [9:0] cnt;
    logic [1:0] lane;
    logic [31:0] sel;
    logic [1:0] gate;
    logic [7:0] flags;
    logic [31:0] done;
    logic [31:0] pend0;
    logic [31:0] pend1;
    logic susp;
    logic rsm_drv;
    logic [17:0] tmr;
    logic hs_v;
    ued_hs_type hs_code;
    logic ram_rd;
    logic ram_wr;
    logic [9:0] ram_addr;
    logic [3:0] ram_be;
    logic [31:0] ram_wdata;
  } ued_regs_type;
endpackage

// ### verif/ued_ram_model.sv
// Packet RAM model standing on the engine's memory port.
// Assumes word addressing and read data one cycle after the strobe.
`timescale 1ns/100ps
module ued_ram_model (
  input wire logic clk_in, // System clock.
  input wire logic rd_in, // Read strobe.
  input wire logic wr_in, // Write strobe.
  input wire logic [9:0] addr_in, // Word index.
  input wire logic [3:0] be_in, // Byte enables.
  input wire logic [31:0] wdata_in, // Write data.
  output logic [31:0] rdata_out // Read data.
);
  // 1024 words give the 4096-byte shared RAM.
  logic [31:0] mem [1024];
  initial begin
    rdata_out = 32'h0;
    foreach (mem[i]) begin
      mem[i] = 32'h0;
    end
  end
  // Data flips outside a read so a late sample never sees a stale word.
  always @(posedge clk_in) begin
    if (rd_in) begin
      rdata_out <= mem[addr_in];
    end else begin
      rdata_out <= ~rdata_out;
    end
    for (int b = 0; b < 4; b++) begin
      if (wr_in && be_in[b]) begin
        mem[addr_in][8*b +: 8] <= wdata_in[8*b +: 8];
      end
    end
  end
endmodule

// ### verif/usb_device_endpoint_engine_test.sv
// Self-checking bench for the endpoint engine with a packet RAM model.
// Assumes the engine and its package; the bench plays the serial side.
`timescale 1ns/100ps
module usb_device_endpoint_engine_test;
  import ued_pkg::*;
  logic clk, rst, tok_v, rx_v, rx_end, rx_pid, ack, rmt, sof, sof_on;
  logic tx_rdy, tx_v, tx_last, tx_pid, ram_rd, ram_wr, susp, rsm, hs_v;
  logic txl, txp, rx_err, tmo, tx_zlp;
  ued_token_type tok_pid;
  ued_hs_type hs_c;
  logic [1:0] arm_set, arm, hs_last;
  logic [3:0] tok_ep, ram_be, hs_cnt;
  logic [7:0] rx_b, st_clr, status, tx_b;
  logic [9:0] ram_a;
  logic [31:0] done, pend0, pend1, ram_wd, ram_q, d_clr, p_clr;
  logic [7:0] txq [$];
  int num_errors, checked, cyc;
  // Short suspend and resume counts keep the run brief.
  ued_engine #(.SUSP_CYCLES(20), .RSM_CYCLES(10)) ued_engine_inst (
    .CLK_IN(clk), .SYS_RST_IN(rst), .TOKEN_VALID_IN(tok_v),
    .TOKEN_PID_IN(tok_pid), .TOKEN_EP_IN(tok_ep), .RX_VALID_IN(rx_v),
    .RX_BYTE_IN(rx_b), .RX_END_IN(rx_end), .RX_PID_IN(rx_pid),
    .RX_ERR_IN(rx_err), .ACK_IN(ack), .TIMEOUT_IN(tmo), .SOF_IN(sof),
    .EP0_IRQ_BUF_IN(1'b1), .EP0_IRQ_STALL_IN(1'b1), .EP0_IRQ_NAK_IN(1'b1),
    .REMOTE_RESUME_IN(rmt), .STALL_ARM_SET_IN(arm_set),
    .STALL_ARM_OUT(arm), .STATUS_CLR_IN(st_clr), .STATUS_OUT(status),
    .DONE_CLR_IN(d_clr), .DONE_OUT(done), .PEND_CLR_IN(p_clr),
    .PEND0_OUT(pend0), .PEND1_OUT(pend1), .SUSPENDED_OUT(susp),
    .RESUME_DRIVE_OUT(rsm), .HS_VALID_OUT(hs_v), .HS_CODE_OUT(hs_c),
    .TX_VALID_OUT(tx_v), .TX_READY_IN(tx_rdy), .TX_BYTE_OUT(tx_b),
    .TX_LAST_OUT(tx_last), .TX_ZLP_OUT(tx_zlp), .TX_PID_OUT(tx_pid),
    .RAM_RD_OUT(ram_rd), .RAM_WR_OUT(ram_wr), .RAM_ADDR_OUT(ram_a),
    .RAM_BE_OUT(ram_be), .RAM_WDATA_OUT(ram_wd), .RAM_RDATA_IN(ram_q));
  ued_ram_model ued_ram_model_inst (.clk_in(clk), .rd_in(ram_rd),
    .wr_in(ram_wr), .addr_in(ram_a), .be_in(ram_be), .wdata_in(ram_wd),
    .rdata_out(ram_q));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Handshakes, sent bytes, frames and the hang limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hs_v) begin
      hs_cnt <= hs_cnt + 4'h1;
      hs_last <= hs_c;
    end
    if (tx_v && tx_rdy) begin
      txq.push_back(tx_b);
      txl <= tx_last;
      txp <= tx_pid;
    end
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  always @(negedge clk) sof <= sof_on && (cyc % 10 == 0);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // A token also clears the sticky flags, so each test sees its own.
  task tok(input ued_token_type p, input logic [3:0] e);
    @(negedge clk);
    tok_v = 1;
    tok_pid = p;
    tok_ep = e;
    hs_cnt = 0;
    st_clr = 8'hff;
    @(negedge clk);
    tok_v = 0;
    st_clr = 8'h0;
    repeat (6) @(negedge clk);
  endtask
  task rx(input int n, input logic [7:0] b0, input logic p);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx_v = 1;
      rx_b = b0 + 8'(i);
      @(negedge clk);
      rx_v = 0;
    end
    @(negedge clk);
    rx_end = 1;
    rx_pid = p;
    @(negedge clk);
    rx_end = 0;
  endtask
  task wait_hs();
    for (int i = 0; i < 30 && hs_cnt == 0; i++) @(negedge clk);
  endtask
  task arm_gate(input logic [1:0] a);
    @(negedge clk);
    arm_set = a;
    @(negedge clk);
    arm_set = 2'h0;
  endtask
  initial begin
    {rst, tok_v, rx_v, rx_end, rx_pid, ack, rmt, tx_rdy} = 8'h80;
    {tok_ep, rx_b, st_clr, arm_set, hs_cnt, hs_last} = 0;
    {rx_err, tmo, d_clr, p_clr} = 66'h0;
    tok_pid = TK_SETUP;
    sof_on = 1;
    repeat (8) @(negedge clk);
    rst = 0;
    arm_gate(2'h3);
    chk(arm, 2'h3);
    tok(TK_SETUP, 4'h0);
    rx(8, 8'h10, 1'b0);
    wait_hs();
    chk({hs_cnt, hs_last, status[0], arm}, {4'h1, HS_ACK, 3'h4});
    chk(ued_ram_model_inst.mem[0], 32'h13121110);
    chk(ued_ram_model_inst.mem[1], 32'h17161514);
    $display("test setup done");
    // Each buffer word is written whole: here stall bit set, available bit clear.
    ued_ram_model_inst.mem[10'h20] = 32'h00000800;
    tok(TK_IN, 4'h0);
    wait_hs();
    chk({hs_cnt, hs_last, status[7]}, {4'h1, HS_NAK, 1'b1});
    arm_gate(2'h1);
    tok(TK_IN, 4'h0);
    wait_hs();
    chk({hs_cnt, hs_last, status[6]}, {4'h1, HS_STALL, 1'b1});
    $display("test stall done");
    ued_ram_model_inst.mem[10'h40] = 32'h44332211;
    ued_ram_model_inst.mem[10'h41] = 32'h00006655;
    ued_ram_model_inst.mem[10'h20] = 32'h0000e406;
    tok(TK_IN, 4'h0);
    repeat (20) @(negedge clk);
    tx_rdy = 1;
    for (int i = 0; i < 100 && txq.size() < 6; i++) @(negedge clk);
    for (int i = 0; i < 6; i++) chk(txq[i], 8'h11 * (i + 1));
    chk({txl, txp}, 2'h3);
    tx_rdy = 0;
    ack = 1;
    @(negedge clk);
    ack = 0;
    repeat (4) @(negedge clk);
    chk(ued_ram_model_inst.mem[10'h20], 32'h00006006);
    chk({status[1], done[0], pend0[0], pend1[0]}, 4'he);
    d_clr = 32'h1;
    p_clr = 32'h1;
    @(negedge clk);
    {d_clr, p_clr} = 64'h0;
    chk({done[0], pend0[0]}, 2'h0);
    $display("test in done");
    ued_ram_model_inst.mem[10'h03] = 32'h28000180;
    ued_ram_model_inst.mem[10'h23] = 32'h00000400;
    tok(TK_OUT, 4'h1);
    rx(3, 8'h20, 1'b1);
    repeat (10) @(negedge clk);
    chk({hs_cnt, status[2]}, 5'h01);
    tok(TK_OUT, 4'h1);
    rx(3, 8'h20, 1'b0);
    wait_hs();
    chk({hs_cnt, hs_last}, {4'h1, HS_ACK});
    repeat (4) @(negedge clk);
    chk(ued_ram_model_inst.mem[10'h23], 32'h00008003);
    chk(ued_ram_model_inst.mem[10'h60], 32'h00222120);
    chk({done[3], pend0[3]}, 2'h3);
    tok(TK_OUT, 4'h1);
    wait_hs();
    chk({hs_cnt, hs_last}, {4'h1, HS_NAK});
    $display("test out done");
    // A zero-length IN that the host never answers: no write-back.
    ued_ram_model_inst.mem[10'h20] = 32'h0000c400;
    tok(TK_IN, 4'h0);
    @(negedge clk);
    tmo = 1;
    @(negedge clk);
    tmo = 0;
    chk({tx_v, tx_zlp, tx_last, status[3]}, 4'hf);
    chk(ued_ram_model_inst.mem[10'h20], 32'h0000c400);
    ued_ram_model_inst.mem[10'h02] = 32'h04000000;
    tok(TK_IN, 4'h1);
    chk(hs_cnt, 4'h0);
    rx_err = 1;
    tok(TK_SETUP, 4'h0);
    rx(8, 8'h10, 1'b0);
    rx_err = 0;
    repeat (4) @(negedge clk);
    chk({hs_cnt, status[0]}, 5'h00);
    $display("test timeout done");
    sof_on = 0;
    repeat (30) @(negedge clk);
    chk({susp, status[4]}, 2'h3);
    rmt = 1;
    @(negedge clk);
    rmt = 0;
    repeat (2) @(negedge clk);
    chk(rsm, 1'b1);
    repeat (15) @(negedge clk);
    chk(rsm, 1'b0);
    sof_on = 1;
    repeat (12) @(negedge clk);
    chk({susp, status[5]}, 2'h1);
    $display("test suspend done");
    wrap_up();
  end
endmodule
